// ### cit_core.sv
// Purpose: Instruction class decoder and data-transfer engine.
// Assumes: Memory answers a held request with a one-cycle ack.
// Notes:   Non-transfer types are classified only, done in one cycle.
`timescale 1ns/1ps
module cit_core
  import cit_pkg::*;
(
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_nrst,
  // Instruction input
  input  wire logic            i_op_valid,
  input  wire logic [OP_W-1:0] i_op,
  input  wire logic [15:0]     i_ext,
  output logic                 o_op_ready,
  // Memory bus
  output logic                 o_bus_req,
  output logic                 o_bus_we,
  output logic                 o_bus_word,
  output logic      [15:0]     o_bus_addr,
  output logic      [15:0]     o_bus_wdata,
  input  wire logic            i_bus_ack,
  input  wire logic [15:0]     i_bus_rdata,
  // Decode result
  output logic                 o_done,
  output logic                 o_undef,
  output logic      [2:0]      o_class,
  output logic      [5:0]      o_type,
  output logic      [3:0]      o_cond
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  cit_state_t  state_q, state_d;
  cit_mode_t   dec_mode, mode_q, mode_d;
  logic [5:0]  dec_type;
  logic        dec_word, dec_store, dec_bad, dec_undef, dec_xfer;
  logic [2:0]  dec_ptr, dec_dat;
  logic        word_q, word_d, store_q, store_d;
  logic [2:0]  ptr_q, ptr_d, dat_q, dat_d;
  logic [15:0] ext_q, ext_d, hold_q, hold_d, pnew_q, pnew_d;
  logic        ready_d, req_d, bwe_d, bword_d, done_d, undef_d;
  logic [15:0] baddr_d, bwdata_d;
  logic [2:0]  class_d;
  logic [5:0]  type_d;
  logic [3:0]  cond_d;
  logic [15:0] rd_a, rd_b, ea, step;
  logic        rf_we;
  logic [2:0]  rf_wa;
  logic [15:0] rf_wd;
  logic        accept;

  assign accept = (state_q == ST_IDLE) && i_op_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decode, push and pop folded onto plain word transfers
  always_comb begin
    dec_type  = i_op[TYPE_MSB:TYPE_LSB];
    dec_mode  = cit_mode_t'(i_op[MODE_MSB:MODE_LSB]);
    dec_word  = i_op[WORD_BIT];
    dec_store = i_op[STORE_BIT];
    dec_ptr   = i_op[PTR_MSB:PTR_LSB];
    dec_dat   = i_op[DAT_MSB:DAT_LSB];
    dec_xfer  = dec_type < ARITH_BASE;
    if (dec_type == T_PUSH) begin
      dec_mode  = M_PREDEC;
      dec_word  = 1'b1;
      dec_store = 1'b1;
      dec_ptr   = SP_IDX;
    end else if (dec_type == T_POP) begin
      dec_mode  = M_POSTINC;
      dec_word  = 1'b1;
      dec_store = 1'b0;
      dec_ptr   = SP_IDX;
    end
    // Illegal size or direction combinations
    dec_bad = ((dec_mode == M_ABS8) && dec_word) ||
              ((dec_mode == M_IMM) && dec_store) ||
              ((dec_mode == M_PREDEC) && !dec_store) ||
              ((dec_mode == M_POSTINC) && dec_store);
    // Codes past the last type, incl. peripheral transfers, and illegal transfers
    dec_undef = (dec_type >= NUM_TYPES) ||
                (dec_xfer && dec_bad);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file holding the general registers
  cit_regfile #(
    .DW (16),
    .AW (3)
  ) u_regs (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_ra   (dec_ptr),
    .i_rb   (dec_dat),
    .o_rd_a (rd_a),
    .o_rd_b (rd_b),
    .i_we   (rf_we),
    .i_wa   (rf_wa),
    .i_wd   (rf_wd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Effective address from the pointer read in the accept cycle
  always_comb begin
    step = size_step(word_q);
    case (mode_q)
      M_IND:    ea = rd_a;
      M_DISP:   ea = rd_a + ext_q;
      M_ABS16:  ea = ext_q;
      M_ABS8:   ea = {ABS8_PAGE, ext_q[7:0]};
      M_PREDEC: ea = rd_a - step;
      default:  ea = rd_a;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next values
  always_comb begin
    state_d  = state_q;
    mode_d   = mode_q;
    word_d   = word_q;
    store_d  = store_q;
    ptr_d    = ptr_q;
    dat_d    = dat_q;
    ext_d    = ext_q;
    hold_d   = hold_q;
    pnew_d   = pnew_q;
    ready_d  = o_op_ready;
    req_d    = o_bus_req;
    bwe_d    = o_bus_we;
    bword_d  = o_bus_word;
    baddr_d  = o_bus_addr;
    bwdata_d = o_bus_wdata;
    done_d   = 1'b0;
    undef_d  = 1'b0;
    class_d  = o_class;
    type_d   = o_type;
    cond_d   = o_cond;
    rf_we    = 1'b0;
    rf_wa    = dat_q;
    rf_wd    = rd_b;
    case (state_q)
      ST_IDLE: begin
        if (i_op_valid) begin
          type_d  = dec_type;
          class_d = type_class(dec_type);
          cond_d  = (dec_type == T_BCC) ?
                    i_op[COND_MSB:COND_LSB] : 4'h0;
          mode_d  = dec_mode;
          word_d  = dec_word;
          store_d = dec_store;
          ptr_d   = dec_ptr;
          dat_d   = dec_dat;
          ext_d   = i_ext;
          if (dec_undef || !dec_xfer) begin
            // Classified only, never touches the bus
            done_d  = 1'b1;
            undef_d = dec_undef;
          end else begin
            ready_d = 1'b0;
            state_d = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        if (mode_q == M_REG || mode_q == M_IMM) begin
          rf_we   = 1'b1;
          rf_wd   = (mode_q == M_REG) ? rd_a : ext_q;
          if (!word_q) begin
            rf_wd = {rd_b[15:8], rf_wd[7:0]};
          end
          done_d  = 1'b1;
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end else begin
          req_d    = 1'b1;
          bwe_d    = store_q;
          bword_d  = word_q;
          baddr_d  = bus_addr(ea, word_q);
          bwdata_d = word_q ? rd_b : {8'h00, rd_b[7:0]};
          hold_d   = rd_b;
          pnew_d   = rd_a + step;
          // Stack modes step by operand size; pre-decrement writes back now
          if (mode_q == M_PREDEC) begin
            rf_we = 1'b1;
            rf_wa = ptr_q;
            rf_wd = ea;
          end
          state_d = ST_BUS;
        end
      end
      ST_BUS: begin
        if (i_bus_ack) begin
          req_d = 1'b0;
          if (!store_q) begin
            rf_we = 1'b1;
            rf_wd = word_q ? i_bus_rdata :
                    {hold_q[15:8], i_bus_rdata[7:0]};
          end
          if (mode_q == M_POSTINC) begin
            state_d = ST_PTR;
          end else begin
            done_d  = 1'b1;
            ready_d = 1'b1;
            state_d = ST_IDLE;
          end
        end
      end
      ST_PTR: begin
        rf_we   = 1'b1;
        rf_wa   = ptr_q;
        rf_wd   = pnew_q;
        done_d  = 1'b1;
        ready_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        ready_d = 1'b1;
        req_d   = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q     <= ST_IDLE;
      mode_q      <= M_REG;
      word_q      <= 1'b0;
      store_q     <= 1'b0;
      ptr_q       <= 3'h0;
      dat_q       <= 3'h0;
      ext_q       <= 16'h0000;
      hold_q      <= 16'h0000;
      pnew_q      <= 16'h0000;
      o_op_ready  <= 1'b1;
      o_bus_req   <= 1'b0;
      o_bus_we    <= 1'b0;
      o_bus_word  <= 1'b0;
      o_bus_addr  <= 16'h0000;
      o_bus_wdata <= 16'h0000;
      o_done      <= 1'b0;
      o_undef     <= 1'b0;
      o_class     <= 3'h0;
      o_type      <= 6'h00;
      o_cond      <= 4'h0;
    end else begin
      state_q     <= state_d;
      mode_q      <= mode_d;
      word_q      <= word_d;
      store_q     <= store_d;
      ptr_q       <= ptr_d;
      dat_q       <= dat_d;
      ext_q       <= ext_d;
      hold_q      <= hold_d;
      pnew_q      <= pnew_d;
      o_op_ready  <= ready_d;
      o_bus_req   <= req_d;
      o_bus_we    <= bwe_d;
      o_bus_word  <= bword_d;
      o_bus_addr  <= baddr_d;
      o_bus_wdata <= bwdata_d;
      o_done      <= done_d;
      o_undef     <= undef_d;
      o_class     <= class_d;
      o_type      <= type_d;
      o_cond      <= cond_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_take_reg;
    accept && !dec_undef && dec_xfer && (dec_mode == M_REG);
  endsequence

  sequence s_load_postinc_ack;
    (state_q == ST_BUS) && i_bus_ack && (mode_q == M_POSTINC);
  endsequence

  chk_undef_no_bus: assert property (
    accept && dec_undef |=> o_undef && o_done && !o_bus_req ##1 !o_bus_req)
    else $error("undefined opcode did not end quietly");

  chk_psync_undef: assert property (
    accept && (dec_type == T_PSYNC_ST || dec_type == T_PSYNC_LD)
    |=> o_undef)
    else $error("peripheral transfer not flagged undefined");

  chk_word_even: assert property (
    o_bus_req && o_bus_word |-> !o_bus_addr[0])
    else $error("word access on odd address");

  chk_abs8_page: assert property (
    o_bus_req && (mode_q == M_ABS8) |-> o_bus_addr[15:8] == ABS8_PAGE
    && !o_bus_word)
    else $error("short absolute access outside top page");

  chk_push_addr: assert property (
    accept && !dec_undef && (dec_type == T_PUSH)
    |=> ##1 o_bus_req && o_bus_we && o_bus_word &&
    (o_bus_addr == (($past(rd_a) - STEP_WORD) & WORD_MASK)))
    else $error("push address not pre-decremented by two");

  chk_postinc_ptr: assert property (
    s_load_postinc_ack |=> (state_q == ST_PTR) && rf_we &&
    (rf_wa == ptr_q) && (rf_wd == pnew_q) ##1 o_done)
    else $error("post-increment pointer not written back");

  chk_bus_hold: assert property (
    o_bus_req && !i_bus_ack |=> o_bus_req && $stable(o_bus_addr)
    && $stable(o_bus_we))
    else $error("bus request dropped before ack");

  chk_reg_move: assert property (
    s_take_reg |-> ##2 o_done && o_op_ready && !o_bus_req)
    else $error("register move not done in two cycles");

  chk_type_range: assert property (
    o_done && !o_undef |-> (o_type < NUM_TYPES) &&
    (o_class == 3'(type_class(o_type))))
    else $error("finished type out of range or misclassed");

  chk_branch_cond: assert property (
    accept && (dec_type == T_BCC) |=> o_cond == $past(i_op[9:6]))
    else $error("branch condition not captured");

endmodule

// ### cit_mem_model.sv
// Purpose: Behavioural model of the internal memory and peripheral bus.
// Assumes: One outstanding request, held by the core until the ack edge.
// Notes:   Read data show the inverse of the last value outside the ack.
`timescale 1ns/1ps
module cit_mem_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Request from the core
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic        i_word,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  // Answer delay in cycles
  input  wire logic [3:0]  i_delay,
  // Answer to the core
  output logic             o_ack,
  output logic      [15:0] o_rdata
);
  logic [7:0]  mem [0:255];
  logic [3:0]  wait_q;
  logic        hold_q;
  logic [15:0] data_q;
  logic [7:0]  ev;
  logic [7:0]  od;

  ////////////////////////////////////////////////////////////////////////////
  // Byte lanes of a word, high byte at the even address
  assign ev = {i_addr[7:1], 1'b0};
  assign od = {i_addr[7:1], 1'b1};
  // Released data lines never show the last value
  assign o_rdata = o_ack ? data_q : ~data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Count the wait, answer once per request
  always_ff @(posedge i_clk) begin
    o_ack <= 1'b0;
    if (!i_nrst || !i_req) begin
      wait_q <= 4'h0;
      hold_q <= 1'b0;
    end else if (!hold_q && wait_q == i_delay) begin
      o_ack  <= 1'b1;
      hold_q <= 1'b1;
      if (i_we && i_word) begin
        mem[ev] <= i_wdata[15:8];
        mem[od] <= i_wdata[7:0];
      end else if (i_we) begin
        mem[i_addr[7:0]] <= i_wdata[7:0];
      end else if (i_word) begin
        data_q <= {mem[ev], mem[od]};
      end else begin
        data_q <= {8'h00, mem[i_addr[7:0]]};
      end
    end else if (!hold_q) begin
      wait_q <= wait_q + 4'h1;
    end
    if (!i_nrst) begin
      data_q <= 16'hA5A5;
    end
  end
endmodule

// ### cit_pkg.sv
// Purpose: Shared constants, types and helpers for the instruction class
//          decoder and data-transfer engine.
// Assumes: One opcode word of OP_W bits plus one 16-bit extension word.
// Notes:   Type codes sit in contiguous ranges, one range per class.
// Function
// - Decoder knows exactly 57 instruction types in eight classes.
// - Transfer copies reg-reg, reg-memory either way, or immediate.
// - Modes: reg, indirect, disp16, abs16, imm, pre-dec, post-inc.
// - Short 8-bit absolute mode exists for byte size only.
// - Push equals word store through pre-decremented stack pointer.
// - Pop equals word load at stack pointer then post-increment.
// - Peripheral-synchronised byte transfers are not supported here.
// - Conditional branch carries a condition code field.
// - Fourteen bit manipulation types are decoded.
// - Eight shift and rotate types are decoded.
// - Eight system control types are decoded.
// - Fourteen arithmetic types are decoded.
// - Word accesses force address bit zero low, no error.
// - Pointer steps by one for bytes and two for words.
package cit_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode word layout
  localparam int OP_W      = 17;
  localparam int TYPE_MSB  = 16;
  localparam int TYPE_LSB  = 11;
  localparam int WORD_BIT  = 10;
  localparam int STORE_BIT = 9;
  localparam int MODE_MSB  = 8;
  localparam int MODE_LSB  = 6;
  localparam int PTR_MSB   = 5;
  localparam int PTR_LSB   = 3;
  localparam int DAT_MSB   = 2;
  localparam int DAT_LSB   = 0;
  localparam int COND_MSB  = 9;
  localparam int COND_LSB  = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Type codes: each class occupies a contiguous range
  localparam logic [5:0] NUM_TYPES   = 6'h39;
  localparam logic [5:0] ARITH_BASE  = 6'h03;
  localparam logic [5:0] LOGIC_BASE  = 6'h11;
  localparam logic [5:0] SHIFT_BASE  = 6'h15;
  localparam logic [5:0] BIT_BASE    = 6'h1D;
  localparam logic [5:0] BRANCH_BASE = 6'h2B;
  localparam logic [5:0] SYS_BASE    = 6'h30;
  localparam logic [5:0] BLOCK_BASE  = 6'h38;
  localparam logic [5:0] T_DATA_XFER = 6'h00;
  localparam logic [5:0] T_PUSH      = 6'h01;
  localparam logic [5:0] T_POP       = 6'h02;
  localparam logic [5:0] T_BCC       = 6'h2B;
  localparam logic [5:0] T_PSYNC_ST  = 6'h39;
  localparam logic [5:0] T_PSYNC_LD  = 6'h3A;

  ////////////////////////////////////////////////////////////////////////////
  // Data path constants
  localparam logic [2:0]  SP_IDX    = 3'h7;
  localparam logic [7:0]  ABS8_PAGE = 8'hFF;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] WORD_MASK = 16'hFFFE;

  typedef enum logic [2:0] {
    CL_XFER = 3'b000, CL_ARITH = 3'b001, CL_LOGIC = 3'b010,
    CL_SHIFT = 3'b011, CL_BIT = 3'b100, CL_BRANCH = 3'b101,
    CL_SYS = 3'b110, CL_BLOCK = 3'b111
  } cit_class_t;

  typedef enum logic [2:0] {
    M_REG = 3'b000, M_IND = 3'b001, M_DISP = 3'b010, M_ABS16 = 3'b011,
    M_ABS8 = 3'b100, M_IMM = 3'b101, M_PREDEC = 3'b110, M_POSTINC = 3'b111
  } cit_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_BUS = 2'b10, ST_PTR = 2'b11
  } cit_state_t;

  // Class of a type code by range
  function automatic cit_class_t type_class(input logic [5:0] t);
    if (t < ARITH_BASE)       return CL_XFER;
    else if (t < LOGIC_BASE)  return CL_ARITH;
    else if (t < SHIFT_BASE)  return CL_LOGIC;
    else if (t < BIT_BASE)    return CL_SHIFT;
    else if (t < BRANCH_BASE) return CL_BIT;
    else if (t < SYS_BASE)    return CL_BRANCH;
    else if (t < BLOCK_BASE)  return CL_SYS;
    else                      return CL_BLOCK;
  endfunction

  // Word accesses drop address bit zero
  function automatic logic [15:0] bus_addr(input logic [15:0] a,
                                           input logic        w);
    return w ? (a & WORD_MASK) : a;
  endfunction

  // Pointer step by operand size
  function automatic logic [15:0] size_step(input logic w);
    return w ? STEP_WORD : STEP_BYTE;
  endfunction

endpackage

// ### cit_regfile.sv
// Purpose: General register file, two registered read ports, one write.
// Assumes: Contents are not initialised by reset.
// Notes:   Read data appear one clock after the address.
`timescale 1ns/1ps
module cit_regfile #(
  parameter int DW = 16,
  parameter int AW = 3
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_nrst,
  // Read ports
  input  wire logic [AW-1:0] i_ra,
  input  wire logic [AW-1:0] i_rb,
  output logic      [DW-1:0] o_rd_a,
  output logic      [DW-1:0] o_rd_b,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_wa,
  input  wire logic [DW-1:0] i_wd
);

  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rd_a_d;
  logic [DW-1:0] rd_b_d;

  ////////////////////////////////////////////////////////////////////////////
  // Read next values
  always_comb begin
    rd_a_d = mem[i_ra];
    rd_b_d = mem[i_rb];
  end

  // Read registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rd_a <= '0;
      o_rd_b <= '0;
    end else begin
      o_rd_a <= rd_a_d;
      o_rd_b <= rd_b_d;
    end
  end

  // Storage array
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_wa] <= i_wd;
    end
  end

endmodule

// ### test_cit_core.sv
// Purpose: Self-checking bench for the class decoder and transfer engine.
// Assumes: Registers are seen only through later stores on the bus.
// Notes:   Class ranges expected from the per-class type counts.
`timescale 1ns/1ps
module test_cit_core
  import cit_pkg::*;
;
  logic            i_clk      = 1'b0;
  logic            i_nrst     = 1'b0;
  logic            i_op_valid = 1'b0;
  logic [OP_W-1:0] i_op       = '0;
  logic [15:0]     i_ext      = 16'h0000;
  logic [3:0]      dly        = 4'h0;
  logic            o_op_ready, o_bus_req, o_bus_we, o_bus_word;
  logic [15:0]     o_bus_addr, o_bus_wdata, i_bus_rdata;
  logic            i_bus_ack, o_done, o_undef;
  logic [2:0]      o_class;
  logic [5:0]      o_type;
  logic [3:0]      o_cond;
  logic [15:0]     b_addr, b_wd;
  logic            b_we, b_word, undef;
  int              mismatches = 0;
  int              num_checks = 0;
  int              n_bus = 0;
  int              bus0, lat;

  always #2.5 i_clk = ~i_clk;

  cit_core i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_op_valid(i_op_valid),
    .i_op(i_op), .i_ext(i_ext), .o_op_ready(o_op_ready),
    .o_bus_req(o_bus_req), .o_bus_we(o_bus_we), .o_bus_word(o_bus_word),
    .o_bus_addr(o_bus_addr), .o_bus_wdata(o_bus_wdata),
    .i_bus_ack(i_bus_ack), .i_bus_rdata(i_bus_rdata), .o_done(o_done),
    .o_undef(o_undef), .o_class(o_class), .o_type(o_type), .o_cond(o_cond));

  cit_mem_model i_mem (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(o_bus_req),
    .i_we(o_bus_we), .i_word(o_bus_word), .i_addr(o_bus_addr),
    .i_wdata(o_bus_wdata), .i_delay(dly), .o_ack(i_bus_ack),
    .o_rdata(i_bus_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Record each completed bus transfer
  always @(posedge i_clk) begin
    if (o_bus_req === 1'b1 && i_bus_ack === 1'b1) begin
      n_bus  = n_bus + 1;
      b_addr = o_bus_addr;
      b_we   = o_bus_we;
      b_word = o_bus_word;
      b_wd   = o_bus_wdata;
    end
  end

  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [OP_W-1:0] mk(input logic [5:0] t,
    input logic w, s, input logic [2:0] m, p, d);
    return {t, w, s, m, p, d};
  endfunction

  // Offer one op, wait for take and for done, all bounded
  task automatic run(input logic [OP_W-1:0] op, input logic [15:0] ext);
    int n;
    n = 0;
    bus0 = n_bus;
    i_op_valid <= 1'b1;
    i_op <= op;
    i_ext <= ext;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_op_ready !== 1'b1 && n < 50);
    i_op_valid <= 1'b0;
    lat = 0;
    do begin
      @(posedge i_clk);
      lat++;
    end while (o_done !== 1'b1 && lat < 50);
    undef = o_undef;
    if (n >= 50 || lat >= 50) begin
      mismatches++;
      $display("[FAIL] handshake expected done seen timeout");
      wrap_up();
    end
  endtask

  // One bus transfer with the given address, direction, size and, for stores only, data
  task automatic chk_bus(input logic [15:0] a, input logic we, w,
                         input logic [15:0] d);
    check("bus count", 16'(n_bus - bus0), 16'h0001);
    check("bus addr", b_addr, a);
    check("bus dir", {15'h0000, b_we}, {15'h0000, we});
    check("bus size", {15'h0000, b_word}, {15'h0000, w});
    if (we) check("bus wdata", b_wd, d);
  endtask

  task automatic t_reset();
    check("ready", {15'h0000, o_op_ready}, 16'h0001);
    check("req", {15'h0000, o_bus_req}, 16'h0000);
    check("done", {15'h0000, o_done}, 16'h0000);
    check("type", {10'h000, o_type}, 16'h0000);
  endtask

  task automatic t_modes();
    dly <= 4'h3;
    run(mk(0, 1, 0, M_IMM, 0, 1), 16'h1234);
    check("imm no bus", 16'(n_bus - bus0), 16'h0000);
    run(mk(0, 1, 0, M_IMM, 0, 2), 16'h0040);
    run(mk(0, 1, 0, M_IMM, 0, 3), 16'h0041);
    run(mk(0, 1, 1, M_IND, 2, 1), 16'h0000);
    chk_bus(16'h0040, 1, 1, 16'h1234);
    run(mk(0, 1, 1, M_IND, 3, 1), 16'h0000);
    chk_bus(16'h0040, 1, 1, 16'h1234);
    dly <= 4'h0;
    run(mk(0, 1, 0, M_ABS16, 0, 6), 16'h0040);
    chk_bus(16'h0040, 0, 1, 16'h0000);
    run(mk(0, 1, 1, M_DISP, 2, 6), 16'h0010);
    chk_bus(16'h0050, 1, 1, 16'h1234);
    run(mk(0, 0, 1, M_ABS8, 0, 6), 16'h0012);
    chk_bus(16'hFF12, 1, 0, 16'h0034);
  endtask

  // Word-only stack traffic through the stack pointer
  task automatic t_stack();
    dly <= 4'h2;
    run(mk(0, 1, 0, M_IMM, 0, SP_IDX), 16'h0080);
    run(mk(T_PUSH, 1, 1, M_PREDEC, SP_IDX, 1), 16'h0000);
    chk_bus(16'h007E, 1, 1, 16'h1234);
    run(mk(T_POP, 1, 0, M_POSTINC, SP_IDX, 4), 16'h0000);
    chk_bus(16'h007E, 0, 1, 16'h0000);
    run(mk(0, 1, 1, M_IND, SP_IDX, 4), 16'h0000);
    chk_bus(16'h0080, 1, 1, 16'h1234);
  endtask

  // Byte pointer steps and low-byte merge
  task automatic t_bytes();
    dly <= 4'h1;
    run(mk(0, 1, 0, M_IMM, 0, 5), 16'hAB00);
    run(mk(0, 0, 1, M_PREDEC, 2, 1), 16'h0000);
    chk_bus(16'h003F, 1, 0, 16'h0034);
    run(mk(0, 0, 0, M_POSTINC, 2, 5), 16'h0000);
    chk_bus(16'h003F, 0, 0, 16'h0000);
    run(mk(0, 1, 0, M_REG, 5, 3), 16'h0000);
    check("reg move lat", 16'(lat), 16'h0002);
    run(mk(0, 1, 1, M_IND, 2, 3), 16'h0000);
    chk_bus(16'h0040, 1, 1, 16'hAB34);
  endtask

  task automatic t_undef();
    logic [OP_W-1:0] ops [7];
    ops = '{mk(T_PSYNC_ST, 0, 1, M_IND, 2, 1),
            mk(T_PSYNC_LD, 0, 0, M_IND, 2, 1), mk(6'h3F, 0, 0, 0, 0, 0),
            mk(0, 1, 1, M_ABS8, 0, 1), mk(0, 1, 1, M_IMM, 0, 1),
            mk(0, 1, 0, M_PREDEC, 2, 1), mk(0, 1, 1, M_POSTINC, 2, 1)};
    foreach (ops[i]) begin
      run(ops[i], 16'h0012);
      check("undef", {15'h0000, undef}, 16'h0001);
      check("undef bus", 16'(n_bus - bus0), 16'h0000);
    end
  endtask

  task automatic t_classes();
    int lim [8];
    int k;
    lim = '{3, 17, 21, 29, 43, 48, 56, 57};
    for (int t = 3; t < 57; t++) begin
      k = 0;
      while (t >= lim[k]) k++;
      run(mk(t[5:0], 0, 0, M_REG, 0, 0), 16'h0000);
      check("class", 16'(o_class), 16'(k));
      check("type", {10'h000, o_type}, 16'(t));
      check("lat", 16'(lat), 16'h0001);
      check("defined", {15'h0000, undef}, 16'h0000);
    end
    for (int c = 0; c < 16; c++) begin
      run(mk(T_BCC, 0, c[3], c[2:0], 0, 0), 16'h0000);
      check("cond", {12'h000, o_cond}, 16'(c));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_modes();
    t_stack();
    t_bytes();
    t_undef();
    t_classes();
    wrap_up();
  end
endmodule
